// [logic/margin_bank_map.svh]
/*
  Constants of the margin register bank: offsets, fields, resets, timing.
  Assumes inclusion by the bank module only.
*/
// Functional notes
// - Margin-high code held left-aligned in bits 11..2; 8-bit mode drops 3..2; resets 0.
// - Margin-low code held the same way as margin-high; resets 0.
// - Operation field bits 15..8, read/write; 00h off, 80h on; resets 00h.
// - Writing A4h to operation moves output code to margin-high code.
// - Writing 94h to operation moves output code to margin-low code.
// - Status bit 9 sets on timeout, wrong clock count, or read before command.
// - Host clears fault flag by writing one; flag then reads zero.
// - Version register at 98h is read-only and reads 2200h.
// - Margin-high at 25h, margin-low at 26h, operation at 01h.
// - Status register at 78h; its other bits are zero.
`ifndef MARGIN_BANK_MAP_SVH
`define MARGIN_BANK_MAP_SVH

// ==========================================================================
// Register offsets
`define OFS_OPERATION     8'h01
`define OFS_MARGIN_UPPER  8'h25
`define OFS_MARGIN_LOWER  8'h26
`define OFS_BUS_STATUS    8'h78
`define OFS_PROTOCOL_REV  8'h98

// ==========================================================================
// Fields and reset values
`define CODE_MSB          11
`define CODE_LSB          2
`define CODE_MASK_10      16'h0FFC
`define CODE_MASK_8       16'h0FF0
`define FAULT_BIT         9
`define REV_VALUE         16'h2200
`define OP_RESET          8'h00
`define OP_OFF            8'h00
`define OP_ON             8'h80
`define OP_MARGIN_HIGH    8'hA4
`define OP_MARGIN_LOW     8'h94

// ==========================================================================
// Timing: bus-stuck timeout
`define CLK_MHZ           25
`define TIMEOUT_US        35000
`define TIMEOUT_CYCLES    (`TIMEOUT_US * `CLK_MHZ)

`endif

// [logic/margin_bank_pkg.sv]
/*
  Types of the margin register bank: serial protocol states, write request.
  Assumes the map header for constants.
*/
package margin_bank_pkg;

    // ======================================================================
    // Serial protocol phase
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_DATA_HI,
        ST_DATA_LO,
        ST_EXTRA,
        ST_READ,
        ST_IGNORE
    } phase_e;

    // Completed 16-bit register write
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } wr_req_s;

endpackage : margin_bank_pkg

// [logic/pmbus_margin_register_bank.sv]
/*
  Margin register bank behind a two-wire serial management slave.
  Assumes SCL and SDA arrive asynchronously and are far slower than CLK;
  SDA is open drain, resolved outside from SDA_OE.
*/
`timescale 1ns/100ps
`include "margin_bank_map.svh"

module pmbus_margin_register_bank
    import margin_bank_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR       = 7'h48,
    parameter logic        EIGHT_BIT      = 1'b0,
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output wire logic       SDA_OUT,
    output wire logic       SDA_OE,
    input  wire logic [9:0] NOMINAL_CODE,
    output wire logic [9:0] OUT_CODE,
    output wire logic       OUT_ON
);

    // ======================================================================
    // Declarations
    logic        scl_s1_r, scl_s2_r, scl_s3_r;
    logic        sda_s1_r, sda_s2_r, sda_s3_r;
    logic        scl_rise, scl_fall, start_det, stop_det;
    phase_e      state_r;
    logic [3:0]  bitcnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic [7:0]  hi_r;
    logic [1:0]  rcnt_r;
    logic        cmd_seen_r;
    logic        oe_r;
    logic        fault_evt_r;
    logic        timeout;
    logic [19:0] tmo_cnt_r;
    wr_req_s     wr_r;
    logic [15:0] mhi_r, mlo_r;
    logic [7:0]  op_r;
    logic [9:0]  code_r;
    logic        fault_r;
    logic [15:0] rd_word;

    // Strip bits outside the code field, and bits 3..2 in 8-bit mode
    function automatic logic [15:0] code_mask(input logic [15:0] d);
        code_mask = d & (EIGHT_BIT ? `CODE_MASK_8 : `CODE_MASK_10);
    endfunction : code_mask

    // ======================================================================
    // Pin synchronisers and bus condition detection
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
        end else begin
            scl_s1_r <= SCL;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= SDA_IN;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    assign scl_rise  = scl_s2_r & ~scl_s3_r;
    assign scl_fall  = ~scl_s2_r & scl_s3_r;
    assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
    assign stop_det  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
    assign timeout   = (tmo_cnt_r >= 20'(TIMEOUT_CYCLES - 1));

    // ======================================================================
    // Clock-low watchdog during a transaction
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tmo_cnt_r <= 20'h00000;
        end else if (state_r == ST_IDLE || scl_s2_r || timeout) begin
            tmo_cnt_r <= 20'h00000;
        end else begin
            tmo_cnt_r <= tmo_cnt_r + 20'h00001;
        end
    end

    // ======================================================================
    // Read word for the current pointer
    always_comb begin
        unique case (ptr_r)
            `OFS_OPERATION:    rd_word = {op_r, 8'h00};
            `OFS_BUS_STATUS:   rd_word = 16'(fault_r) << `FAULT_BIT;
            `OFS_PROTOCOL_REV: rd_word = `REV_VALUE;
            default:           rd_word = 16'h0000;
        endcase
    end

    // ======================================================================
    // Serial protocol engine: bits sampled on SCL rise, driven on SCL fall
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r     <= ST_IDLE;
            bitcnt_r    <= 4'h0;
            sh_r        <= 8'h00;
            tx_r        <= 8'h00;
            ptr_r       <= 8'h00;
            hi_r        <= 8'h00;
            rcnt_r      <= 2'h0;
            cmd_seen_r  <= 1'b0;
            oe_r        <= 1'b0;
            fault_evt_r <= 1'b0;
            wr_r        <= '0;
        end else begin
            fault_evt_r <= 1'b0;
            wr_r.valid  <= 1'b0;
            if (timeout) begin
                state_r     <= ST_IDLE;
                oe_r        <= 1'b0;
                cmd_seen_r  <= 1'b0;
                fault_evt_r <= 1'b1;
            end else if (start_det) begin
                state_r  <= ST_ADDR;
                bitcnt_r <= 4'h8;                                    // Clock fall after START opens bit 0
                oe_r     <= 1'b0;
            end else if (stop_det) begin
                // Partial command or data byte, or lone high byte, is a wrong clock count
                if (state_r == ST_DATA_LO ||
                    ((state_r == ST_CMD || state_r == ST_DATA_HI) && bitcnt_r != 4'h0)) begin
                    fault_evt_r <= 1'b1;
                end
                state_r    <= ST_IDLE;
                oe_r       <= 1'b0;
                cmd_seen_r <= 1'b0;
            end else if (scl_rise && state_r != ST_IDLE) begin
                if (bitcnt_r != 4'h8) begin
                    sh_r <= {sh_r[6:0], sda_s2_r};
                end else if (state_r == ST_READ && sda_s2_r) begin
                    state_r <= ST_IGNORE;                            // Host NACK ends read
                end
            end else if (scl_fall && state_r != ST_IDLE) begin
                if (bitcnt_r == 4'h7) begin
                    bitcnt_r <= 4'h8;
                    oe_r     <= 1'b0;
                    unique case (state_r)
                        ST_ADDR: begin
                            if (sh_r[7:1] != DEV_ADDR) begin
                                state_r <= ST_IGNORE;
                            end else if (sh_r[0]) begin
                                oe_r    <= 1'b1;
                                state_r <= ST_READ;
                                tx_r    <= rd_word[15:8];
                                rcnt_r  <= 2'h0;
                                if (!cmd_seen_r) begin
                                    fault_evt_r <= 1'b1;
                                end
                            end else begin
                                oe_r    <= 1'b1;
                                state_r <= ST_CMD;
                            end
                        end
                        ST_CMD: begin
                            oe_r       <= 1'b1;
                            ptr_r      <= sh_r;
                            cmd_seen_r <= 1'b1;
                            state_r    <= ST_DATA_HI;
                        end
                        ST_DATA_HI: begin
                            oe_r    <= 1'b1;
                            hi_r    <= sh_r;
                            state_r <= ST_DATA_LO;
                        end
                        ST_DATA_LO: begin
                            oe_r       <= 1'b1;
                            wr_r.valid <= 1'b1;
                            wr_r.addr  <= ptr_r;
                            wr_r.data  <= {hi_r, sh_r};
                            state_r    <= ST_EXTRA;
                        end
                        ST_EXTRA: begin
                            fault_evt_r <= 1'b1;
                            state_r     <= ST_IGNORE;
                        end
                        ST_READ: begin
                            rcnt_r <= rcnt_r + 2'h1;
                        end
                        ST_IDLE, ST_IGNORE: begin
                        end
                    endcase
                end else if (bitcnt_r == 4'h8) begin
                    bitcnt_r <= 4'h0;
                    if (state_r == ST_READ) begin
                        if (rcnt_r == 2'h0) begin
                            oe_r <= ~tx_r[7];
                        end else begin
                            tx_r <= (rcnt_r == 2'h1) ? rd_word[7:0] : 8'h00;
                            oe_r <= (rcnt_r == 2'h1) ? ~rd_word[7] : 1'b1;
                        end
                    end else begin
                        oe_r <= 1'b0;
                    end
                end else begin
                    bitcnt_r <= bitcnt_r + 4'h1;
                    if (state_r == ST_READ) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        oe_r <= ~tx_r[6];
                    end
                end
            end
        end
    end

    // ======================================================================
    // Register writes and output code update
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mhi_r  <= 16'h0000;
            mlo_r  <= 16'h0000;
            op_r   <= `OP_RESET;
            code_r <= 10'h000;
        end else if (wr_r.valid) begin
            unique case (wr_r.addr)
                `OFS_MARGIN_UPPER: mhi_r <= code_mask(wr_r.data);
                `OFS_MARGIN_LOWER: mlo_r <= code_mask(wr_r.data);
                `OFS_OPERATION: begin
                    op_r <= wr_r.data[15:8];
                    unique case (wr_r.data[15:8])
                        `OP_MARGIN_HIGH: code_r <= mhi_r[`CODE_MSB:`CODE_LSB];
                        `OP_MARGIN_LOW:  code_r <= mlo_r[`CODE_MSB:`CODE_LSB];
                        `OP_ON:          code_r <= NOMINAL_CODE;
                        default:         code_r <= code_r;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // Communication fault flag: a new fault wins over a same-cycle clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fault_r <= 1'b0;
        end else if (fault_evt_r) begin
            fault_r <= 1'b1;
        end else if (wr_r.valid && wr_r.addr == `OFS_BUS_STATUS && wr_r.data[`FAULT_BIT]) begin
            fault_r <= 1'b0;
        end
    end

    assign SDA_OUT  = 1'b0;                                          // Open drain, low only
    assign SDA_OE   = oe_r;
    assign OUT_CODE = code_r;
    assign OUT_ON   = (op_r != `OP_OFF);

endmodule : pmbus_margin_register_bank

// [verification/margin_bank_props.sv]
/*
  Port checks of the margin register bank.
  Assumes a bind onto the bank top module.
*/
`timescale 1ns/100ps
module margin_bank_props (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       SCL,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    input wire logic [9:0] OUT_CODE,
    input wire logic       OUT_ON
);
    // ====================================
    // Checks on CLK, idle during reset
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    AST_OPEN_DRAIN: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    AST_RESET_STATE: assert property ($rose(RSTN) |->
        OUT_CODE == 10'h000 && !OUT_ON && !SDA_OE) else $error("outputs not at reset");
    AST_CODE_NEEDS_ON: assert property ($changed(OUT_CODE) |->
        OUT_ON) else $error("code moved while off");
    AST_OFF_KEEPS_CODE: assert property ($fell(OUT_ON) |->
        $stable(OUT_CODE)) else $error("turn-off moved code");
    AST_IDLE_QUIET: assert property (SCL [*6] |->
        $stable(OUT_CODE) && $stable(OUT_ON)) else $error("output moved on idle clock");
    AST_OE_AFTER_LOW: assert property ($changed(SDA_OE) |->
        !$past(SCL)) else $error("data drive changed in clock high");
    AST_IDLE_RELEASED: assert property (SCL [*6] |->
        !SDA_OE) else $error("data held low on idle bus");
    AST_OE_MIN_BIT: assert property ($rose(SDA_OE) |->
        SDA_OE [*6]) else $error("data drive shorter than a bit");
endmodule : margin_bank_props

bind pmbus_margin_register_bank margin_bank_props props (.CLK(CLK), .RSTN(RSTN), .SCL(SCL),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OUT_CODE(OUT_CODE), .OUT_ON(OUT_ON));

// [verification/serial_host_model.sv]
/*
  Host model on the two-wire management bus.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/100ps
module serial_host_model #(parameter logic [6:0] TARGET = 7'h48) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // Bus idle at time zero
    initial {scl, sda_pull} = 2'b10;
    // Set both lines 1 ns after an edge, hold n cycles
    task automatic drive(input logic d, input logic c, input int n);
        sda_pull = !d;
        scl = c;
        repeat (n) @(posedge clk);
        #1;
    endtask : drive
    // One bit, data moved only while the clock is low
    task automatic put(input logic b, output logic r);
        drive(b, 1'b0, 2);
        drive(b, 1'b1, 2);
        r = sda;
        drive(b, 1'b1, 2);
        drive(b, 1'b0, 2);
    endtask : put
    task automatic start();
        drive(1'b1, scl, 2);
        drive(1'b1, 1'b1, 4);
        drive(1'b0, 1'b1, 4);
        drive(1'b0, 1'b0, 2);
    endtask : start
    task automatic stop();
        drive(1'b0, 1'b0, 2);
        drive(1'b0, 1'b1, 4);
        drive(1'b1, 1'b1, 4);
    endtask : stop
    // Byte MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic r);
        for (int i = 7; i >= 0; i--) begin
            put(d[i], r);
            q = {q[6:0], r};
        end
        put(last, r);
    endtask : xfer
    // Kind 0 write, 1 read, 2 read without command, 3 write cut after high byte
    task automatic txn(input logic [7:0] a, input logic [15:0] w, input logic [1:0] kind,
                       output logic [15:0] q);
        logic [7:0] x;
        logic       r;
        start();
        if (kind != 2'h2) xfer({TARGET, 1'b0}, 1'b1, x, r);
        if (kind != 2'h2) xfer(a, 1'b1, x, r);
        if (kind[0] == kind[1]) xfer(w[15:8], 1'b1, x, r);
        if (kind == 2'h0) xfer(w[7:0], 1'b1, x, r);
        if (kind == 2'h1) start();
        if (kind[0] != kind[1]) xfer({TARGET, 1'b1}, 1'b1, x, r);
        if (kind[0] != kind[1]) xfer(8'hFF, 1'b0, q[15:8], r);
        if (kind[0] != kind[1]) xfer(8'hFF, 1'b1, q[7:0], r);
        stop();
    endtask : txn
endmodule : serial_host_model

// [verification/tb_pmbus_margin_register_bank.sv]
/*
  Self-checking bench of the margin register bank.
  Assumes the serial host model and the bound port checker.
*/
`timescale 1ns/100ps
module tb_pmbus_margin_register_bank;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [9:0]  nominal = 10'h2AA;
    wire  [9:0]  out_code;
    wire         out_on, sda_oe, scl, pull;
    wire         sda = !(pull || sda_oe);
    logic [15:0] v;
    logic [7:0]  ad [6] = '{8'h01, 8'h25, 8'h26, 8'h78, 8'h98, 8'h55};
    logic [7:0]  op [4] = '{8'hA4, 8'h94, 8'h80, 8'h00};
    logic [9:0]  cd [4] = '{10'h297, 10'h155, 10'h2AA, 10'h2AA};
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;

    always #20 clk = ~clk;
    pmbus_margin_register_bank #(.DEV_ADDR(7'h48), .TIMEOUT_CYCLES(200)) dut (
        .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
        .NOMINAL_CODE(nominal), .OUT_CODE(out_code), .OUT_ON(out_on));
    serial_host_model #(.TARGET(7'h48)) host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));

    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task conclude();
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // Reset values, unmapped place, version write ignored
    task s_reset();
        check({5'h00, out_on, out_code}, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            host.txn(ad[i], 16'h0000, 2'h1, v);
            check(v, ad[i] == 8'h98 ? 16'h2200 : 16'h0000);
        end
        host.txn(8'h98, 16'hFFFF, 2'h0, v);
        host.txn(8'h98, 16'h0000, 2'h1, v);
        check(v, 16'h2200);
    endtask : s_reset
    // Each operation code and the output code it selects
    task s_ops();
        host.txn(8'h25, 16'hFA5F, 2'h0, v);
        host.txn(8'h26, 16'h0557, 2'h0, v);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) nominal = 10'h0F0;
            host.txn(8'h01, {op[i], 8'hFF}, 2'h0, v);
            host.txn(8'h01, 16'h0000, 2'h1, v);
            check(v, {op[i], 8'h00});
            check({6'h00, out_code}, {6'h00, cd[i]});
            check({15'h0000, out_on}, {15'h0000, op[i] != 8'h00});
        end
    endtask : s_ops
    // Flag seen, kept on zero, cleared on one
    task clear_fault();
        host.txn(8'h78, 16'h0000, 2'h1, v);
        check(v, 16'h0200);
        host.txn(8'h78, 16'hFDFF, 2'h0, v);
        host.txn(8'h78, 16'h0000, 2'h1, v);
        check(v, 16'h0200);
        host.txn(8'h78, 16'h0200, 2'h0, v);
        host.txn(8'h78, 16'h0000, 2'h1, v);
        check(v, 16'h0000);
    endtask : clear_fault
    // Read before command, short write, stuck clock, foreign address
    task s_fault();
        logic [7:0] x;
        logic       k;
        host.txn(8'h78, 16'h0000, 2'h2, v);
        clear_fault();
        host.txn(8'h01, 16'h8000, 2'h3, v);
        clear_fault();
        check({15'h0000, out_on}, 16'h0000);
        host.start();
        host.xfer(8'h90, 1'b1, x, k);
        host.drive(1'b1, 1'b0, 260);
        host.stop();
        clear_fault();
        host.start();
        host.xfer(8'h22, 1'b1, x, k);
        host.stop();
        check({15'h0000, k}, 16'h0001);
    endtask : s_fault

    // Main sequence after 12 cycles of reset
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        host.drive(1'b1, 1'b1, 4);
        s_reset();
        s_ops();
        s_fault();
        conclude();
    end
    // Cut a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end
endmodule : tb_pmbus_margin_register_bank
